// [rtl/lrs_seq.sv]
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Vertical auto-advance when direction bit is 1, horizontal when 0.
// - Auto-advance never enters the icon bank; host loads bank 8.
// - At bank 8 column wrap leaves the bank pointer at 8.
// - Icon writes step the column alike in both modes, mirror sets sense.
// - Column mirror only steers new writes; stored data is untouched.
// - Vertical plain: bank 0..7 wraps, column increments, 127 sets page.
// - Plain modes: after bank 7 column 132 wrap to bank 0 column 0.
// - Vertical mirrored: bank wraps, column decrements, page toggles.
// - Horizontal plain: column 0..132 then wraps, bank increments.
// - Horizontal mirrored: column 132 down to 0, wraps, bank increments.
// - Mirrored modes: after bank 7 column 0 wrap to bank 0 column 132.
// - Refresh read addresses are generated internally per multiplex rate.
// - Row mirror reverses drive order from the next line launched, no RAM rewrite.
// - Bottom swap reverses row order inside each bottom-edge block.
// - Top swap reverses row order inside each top-edge block.
// - RAM rows are read linearly from zero, then the icon row.
// - No swaps: rows 0..N-2 then icon pad 64; mirror reverses.
// - Bottom swap only: 15..0, 16..32, 47..33, 48..64 at 1:65.
// - Top swap only: icon on pad 48, blocks 16..32, 48..64 reversed.
// - Both swaps: all four blocks reversed, icon on pad 48.
// - Column pointer 7 bits plus page bit; bank pointer 0..8.
// - Pointers advance only on accepted data writes.
// - Column mirror maps pointer value v to column 132 minus v.
module lrs_seq #(
  parameter int LINE_CYCLES = 64
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_ram_we,
  output logic [7:0] o_ram_col,
  output logic [3:0] o_ram_bank,
  output logic [7:0] o_ram_data,
  output logic o_scan_strobe,
  output logic [6:0] o_scan_row,
  output logic [6:0] o_scan_ram_row
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [6:0] mux_len(input logic [2:0] m);
    unique case (m)
      lrs_pkg::MUX_17: mux_len = lrs_pkg::LEN_17;
      lrs_pkg::MUX_26: mux_len = lrs_pkg::LEN_26;
      lrs_pkg::MUX_33: mux_len = lrs_pkg::LEN_33;
      lrs_pkg::MUX_49: mux_len = lrs_pkg::LEN_49;
      default: mux_len = lrs_pkg::LEN_65;
    endcase
  endfunction

  // Pad for a scan step; swaps act on pads after the mirror
  function automatic logic [6:0] pad_row(input logic [6:0] k,
      input logic [6:0] len, input logic my, input logic bottom_row_swap,
      input logic top_row_swap);
    logic [6:0] p;
    p = k;
    if (k >= len) begin
      p = top_row_swap ? lrs_pkg::ICON_PAD_TOP : lrs_pkg::ICON_RAM_ROW;
    end else begin
      if (my) begin
        p = len - 7'h01 - k;
      end
      if (bottom_row_swap) begin
        if (p <= lrs_pkg::BOT_A_HI) begin
          p = lrs_pkg::BOT_A_HI - p;
        end else if (p >= lrs_pkg::BOT_B_LO && p <= lrs_pkg::BOT_B_HI) begin
          p = lrs_pkg::BOT_B_SUM - p;
        end
      end
      if (top_row_swap) begin
        if (p >= lrs_pkg::TOP_A_LO && p <= lrs_pkg::TOP_A_HI) begin
          p = lrs_pkg::TOP_A_SUM - p;
        end else if (p >= lrs_pkg::TOP_B_LO && p <= lrs_pkg::TOP_B_HI) begin
          p = lrs_pkg::TOP_B_SUM - p;
        end
      end
    end
    pad_row = p;
  endfunction

  // Next {bank, page+column} after one data write
  function automatic logic [11:0] advance(input logic [3:0] y,
      input logic [7:0] c, input logic vert, input logic mir);
    logic [7:0] c_up;
    logic [7:0] c_dn;
    logic [3:0] y_up;
    c_up = (c == lrs_pkg::COL_LAST) ? lrs_pkg::COL_FIRST : c + 8'h01;
    c_dn = (c == lrs_pkg::COL_FIRST) ? lrs_pkg::COL_LAST : c - 8'h01;
    y_up = (y == lrs_pkg::BANK_LAST) ? lrs_pkg::BANK_FIRST : y + 4'h1;
    if (y == lrs_pkg::BANK_ICON) begin
      advance = {y, mir ? c_dn : c_up};
    end else if (vert) begin
      // Bank runs first, column steps on bank wrap
      if (y == lrs_pkg::BANK_LAST) begin
        advance = {y_up, mir ? c_dn : c_up};
      end else begin
        advance = {y_up, c};
      end
    end else if (mir) begin
      if (c == lrs_pkg::COL_FIRST) begin
        advance = {y_up, c_dn};
      end else begin
        advance = {y, c_dn};
      end
    end else if (c == lrs_pkg::COL_LAST) begin
      advance = {y_up, c_up};
    end else begin
      advance = {y, c_up};
    end
  endfunction

  // ****************************************************
  // Register file and write pointers
  // ****************************************************
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] col_r, col_nxt;
  logic [3:0] bank_r, bank_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic we_r, we_nxt;
  logic [7:0] wcol_r, wcol_nxt;
  logic [3:0] wbank_r, wbank_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic [6:0] step_r, step_nxt;
  logic data_wr;
  logic cmir;
  logic [11:0] adv;

  assign data_wr = i_wr && (i_addr == lrs_pkg::ADDR_DATA);
  assign cmir = ctrl_r[lrs_pkg::CTRL_CMIR];
  assign adv = advance(bank_r, col_r, ctrl_r[lrs_pkg::CTRL_DIR], cmir);

  always_comb begin
    ctrl_nxt = ctrl_r;
    col_nxt = col_r;
    bank_nxt = bank_r;
    rdata_nxt = 8'h00;
    we_nxt = 1'b0;
    wcol_nxt = wcol_r;
    wbank_nxt = wbank_r;
    wdat_nxt = wdat_r;
    if (i_wr) begin
      unique case (i_addr)
        lrs_pkg::ADDR_CTRL: ctrl_nxt = i_wdata;
        lrs_pkg::ADDR_XPTR: col_nxt = i_wdata;
        lrs_pkg::ADDR_YPTR: bank_nxt = i_wdata[3:0];
        lrs_pkg::ADDR_DATA: begin
          // Mirror picks the column of this byte and the step sense
          we_nxt = 1'b1;
          wcol_nxt = cmir ? lrs_pkg::COL_LAST - col_r : col_r;
          wbank_nxt = bank_r;
          wdat_nxt = i_wdata;
          {bank_nxt, col_nxt} = adv;
        end
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        lrs_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
        lrs_pkg::ADDR_XPTR: rdata_nxt = col_r;
        lrs_pkg::ADDR_YPTR: rdata_nxt = {4'h0, bank_r};
        lrs_pkg::ADDR_STAT: rdata_nxt = {1'b0, step_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= lrs_pkg::CTRL_RESET;
      col_r <= lrs_pkg::COL_FIRST;
      bank_r <= lrs_pkg::BANK_FIRST;
      rdata_r <= 8'h00;
      we_r <= 1'b0;
      wcol_r <= 8'h00;
      wbank_r <= 4'h0;
      wdat_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      col_r <= col_nxt;
      bank_r <= bank_nxt;
      rdata_r <= rdata_nxt;
      we_r <= we_nxt;
      wcol_r <= wcol_nxt;
      wbank_r <= wbank_nxt;
      wdat_r <= wdat_nxt;
    end
  end

  // ****************************************************
  // Refresh row scan
  // ****************************************************
  logic [15:0] tick_r, tick_nxt;
  logic strobe_r, strobe_nxt;
  logic [6:0] srow_r, srow_nxt;
  logic [6:0] sram_r, sram_nxt;
  logic [7:0] ctrl_line_r, ctrl_line_nxt;
  logic [6:0] len;

  assign len = mux_len(ctrl_r[lrs_pkg::CTRL_MUX_LO +: 3]);

  always_comb begin
    tick_nxt = tick_r + 16'h0001;
    step_nxt = step_r;
    strobe_nxt = 1'b0;
    srow_nxt = srow_r;
    sram_nxt = sram_r;
    ctrl_line_nxt = ctrl_line_r;
    if (tick_r == 16'(LINE_CYCLES - 1)) begin
      // Control in force for the line being launched
      ctrl_line_nxt = ctrl_r;
      // Settings are sampled per line, so mirror acts on the next line
      tick_nxt = 16'h0000;
      strobe_nxt = 1'b1;
      srow_nxt = pad_row(step_r, len, ctrl_r[lrs_pkg::CTRL_RMIR],
          ctrl_r[lrs_pkg::CTRL_BRS], ctrl_r[lrs_pkg::CTRL_TRS]);
      sram_nxt = (step_r >= len) ? lrs_pkg::ICON_RAM_ROW : step_r;
      step_nxt = (step_r >= len) ? 7'h00 : step_r + 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_r <= 16'h0000;
      step_r <= 7'h00;
      strobe_r <= 1'b0;
      srow_r <= 7'h00;
      sram_r <= 7'h00;
      ctrl_line_r <= lrs_pkg::CTRL_RESET;
    end else begin
      ctrl_line_r <= ctrl_line_nxt;
      tick_r <= tick_nxt;
      step_r <= step_nxt;
      strobe_r <= strobe_nxt;
      srow_r <= srow_nxt;
      sram_r <= sram_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_ram_we = we_r;
  assign o_ram_col = wcol_r;
  assign o_ram_bank = wbank_r;
  assign o_ram_data = wdat_r;
  assign o_scan_strobe = strobe_r;
  assign o_scan_row = srow_r;
  assign o_scan_ram_row = sram_r;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  icon_bank_hold_a: assert property (
    data_wr && bank_r == lrs_pkg::BANK_ICON |=> bank_r == lrs_pkg::BANK_ICON)
    else $error("icon bank left on write");
  vert_page_set_a: assert property (
    data_wr && ctrl_r[0] && !cmir && bank_r == 4'h7 && col_r == 8'h7F
    |=> col_r == 8'h80 && bank_r == 4'h0)
    else $error("vertical page set wrong");
  plain_last_wrap_a: assert property (
    data_wr && !cmir && bank_r == 4'h7 && col_r == 8'h84
    |=> col_r == 8'h00 && bank_r == 4'h0)
    else $error("plain last wrap wrong");
  vert_mir_step_a: assert property (
    data_wr && ctrl_r[0] && cmir && bank_r == 4'h7 && col_r == 8'h80
    |=> col_r == 8'h7F && bank_r == 4'h0)
    else $error("vertical mirror page toggle wrong");
  horz_step_a: assert property (
    data_wr && !ctrl_r[0] && !cmir && bank_r < 4'h8 && col_r != 8'h84
    |=> col_r == $past(col_r) + 8'h01 && bank_r == $past(bank_r))
    else $error("horizontal step wrong");
  horz_mir_step_a: assert property (
    data_wr && !ctrl_r[0] && cmir && bank_r < 4'h7 && col_r == 8'h00
    |=> col_r == 8'h84 && bank_r == $past(bank_r) + 4'h1)
    else $error("horizontal mirror wrap wrong");
  mir_last_wrap_a: assert property (
    data_wr && cmir && bank_r == 4'h7 && col_r == 8'h00
    |=> col_r == 8'h84 && bank_r == 4'h0)
    else $error("mirrored last wrap wrong");
  no_cmd_move_a: assert property (
    !i_wr |=> col_r == $past(col_r) && bank_r == $past(bank_r))
    else $error("pointer moved without write");
  col_map_a: assert property (
    data_wr |=> o_ram_we && o_ram_col ==
      ($past(cmir) ? 8'h84 - $past(col_r) : $past(col_r)))
    else $error("column mapping wrong");
  scan_linear_a: assert property (
    o_scan_strobe && o_scan_ram_row < 7'h3F &&
    o_scan_ram_row <
      mux_len(ctrl_line_r[lrs_pkg::CTRL_MUX_LO +: 3]) - 7'h01
    |-> ##(LINE_CYCLES) o_scan_strobe &&
      (ctrl_line_r[lrs_pkg::CTRL_MUX_LO +: 3] !=
      $past(ctrl_line_r[lrs_pkg::CTRL_MUX_LO +: 3], LINE_CYCLES) ||
      o_scan_ram_row == $past(o_scan_ram_row, LINE_CYCLES) + 7'h01))
    else $error("scan rows not linear");

  vert_wrap_c: cover property (data_wr && ctrl_r[0] && bank_r == 4'h7);
  mir_wrap_c: cover property (data_wr && cmir && col_r == 8'h00);
  icon_write_c: cover property (data_wr && bank_r == lrs_pkg::BANK_ICON);
  scan_icon_c: cover property (o_scan_strobe && o_scan_ram_row == 7'h40);

endmodule // lrs_seq

`default_nettype wire

// [rtl/lrs_pkg.sv]
package lrs_pkg;
  // ****************************************************
  // Register map (byte offsets on the plain port)
  // ****************************************************
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_XPTR = 3'h1;
  localparam logic [2:0] ADDR_YPTR = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_STAT = 3'h4;

  // CTRL field positions
  localparam int CTRL_DIR = 0;
  localparam int CTRL_CMIR = 1;
  localparam int CTRL_RMIR = 2;
  localparam int CTRL_BRS = 3;
  localparam int CTRL_TRS = 4;
  localparam int CTRL_MUX_LO = 5;
  localparam logic [7:0] CTRL_RESET = 8'h80;

  // ****************************************************
  // Write pointer limits
  // ****************************************************
  localparam logic [7:0] COL_LAST = 8'h84;
  localparam logic [7:0] COL_FIRST = 8'h00;
  localparam logic [3:0] BANK_LAST = 4'h7;
  localparam logic [3:0] BANK_ICON = 4'h8;
  localparam logic [3:0] BANK_FIRST = 4'h0;

  // ****************************************************
  // Multiplex codes and non-icon line counts
  // ****************************************************
  localparam logic [2:0] MUX_17 = 3'h0;
  localparam logic [2:0] MUX_26 = 3'h1;
  localparam logic [2:0] MUX_33 = 3'h2;
  localparam logic [2:0] MUX_49 = 3'h3;
  localparam logic [6:0] LEN_17 = 7'h10;
  localparam logic [6:0] LEN_26 = 7'h19;
  localparam logic [6:0] LEN_33 = 7'h20;
  localparam logic [6:0] LEN_49 = 7'h30;
  localparam logic [6:0] LEN_65 = 7'h40;

  // ****************************************************
  // Row pad blocks
  // ****************************************************
  localparam logic [6:0] ICON_RAM_ROW = 7'h40;
  localparam logic [6:0] ICON_PAD_TOP = 7'h30;
  localparam logic [6:0] BOT_A_HI = 7'h0F;
  localparam logic [6:0] BOT_B_LO = 7'h21;
  localparam logic [6:0] BOT_B_HI = 7'h2F;
  localparam logic [6:0] BOT_B_SUM = 7'h50;
  localparam logic [6:0] TOP_A_LO = 7'h10;
  localparam logic [6:0] TOP_A_HI = 7'h20;
  localparam logic [6:0] TOP_A_SUM = 7'h30;
  localparam logic [6:0] TOP_B_LO = 7'h30;
  localparam logic [6:0] TOP_B_HI = 7'h40;
  localparam logic [6:0] TOP_B_SUM = 7'h70;
endpackage

// [verification/lrs_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Host side of the register port
// ****************************************************
module lrs_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 3'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Only legal pointer values are ever loaded
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    // Released bus shows junk, not the old value
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule // lrs_host
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, ram_col, ram_data, v;
  logic wr, rd, ram_we, strobe;
  logic [3:0] ram_bank;
  logic [6:0] scan_row, scan_ram_row;
  int n_errors = 0;
  int checks = 0;
  always #12.5 i_clk = ~i_clk;
  lrs_host i_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  lrs_seq #(.LINE_CYCLES(4)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_ram_we(ram_we), .o_ram_col(ram_col),
    .o_ram_bank(ram_bank), .o_ram_data(ram_data),
    .o_scan_strobe(strobe), .o_scan_row(scan_row),
    .o_scan_ram_row(scan_ram_row));
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    i_host.rd(a, v);
    `CHK(v, e)
  endtask
  // ****************************************************
  // Register port and write pointers
  // ****************************************************
  task automatic reset_test();
    `CHK(ram_we, 1'b0)
    rd_chk(lrs_pkg::ADDR_CTRL, lrs_pkg::CTRL_RESET);
    rd_chk(lrs_pkg::ADDR_XPTR, 8'h00);
    rd_chk(lrs_pkg::ADDR_YPTR, 8'h00);
    rd_chk(3'h7, 8'h00);
    @(negedge i_clk);
    `CHK(rdata, 8'h00)
    $display("test reset done");
  endtask
  task automatic ptr(input logic [7:0] c, y, x, col, ny, nx);
    i_host.wr(lrs_pkg::ADDR_CTRL, c);
    i_host.wr(lrs_pkg::ADDR_YPTR, y);
    i_host.wr(lrs_pkg::ADDR_XPTR, x);
    i_host.wr(lrs_pkg::ADDR_DATA, x ^ 8'h5A);
    @(negedge i_clk);
    `CHK(ram_we, 1'b1)
    `CHK(ram_col, col)
    `CHK(ram_bank, y[3:0])
    `CHK(ram_data, x ^ 8'h5A)
    @(negedge i_clk);
    `CHK(ram_we, 1'b0)
    rd_chk(lrs_pkg::ADDR_XPTR, nx);
    rd_chk(lrs_pkg::ADDR_YPTR, ny);
  endtask
  task automatic ptr_test();
    ptr(8'h80, 8'h07, 8'h84, 8'h84, 8'h00, 8'h00);
    ptr(8'h80, 8'h03, 8'h7F, 8'h7F, 8'h03, 8'h80);
    ptr(8'h81, 8'h07, 8'h7F, 8'h7F, 8'h00, 8'h80);
    ptr(8'h81, 8'h07, 8'h84, 8'h84, 8'h00, 8'h00);
    ptr(8'h81, 8'h02, 8'h10, 8'h10, 8'h03, 8'h10);
    ptr(8'h82, 8'h07, 8'h00, 8'h84, 8'h00, 8'h84);
    ptr(8'h82, 8'h01, 8'h80, 8'h04, 8'h01, 8'h7F);
    ptr(8'h83, 8'h07, 8'h80, 8'h04, 8'h00, 8'h7F);
    ptr(8'h83, 8'h07, 8'h00, 8'h84, 8'h00, 8'h84);
    // Icon bank is only reached by loading 8
    ptr(8'h80, 8'h08, 8'h84, 8'h84, 8'h08, 8'h00);
    ptr(8'h81, 8'h08, 8'h10, 8'h10, 8'h08, 8'h11);
    ptr(8'h83, 8'h08, 8'h00, 8'h84, 8'h08, 8'h84);
    $display("test pointers done");
  endtask
  task automatic cmd_test();
    i_host.wr(lrs_pkg::ADDR_XPTR, 8'h20);
    i_host.wr(lrs_pkg::ADDR_CTRL, 8'h82);
    @(negedge i_clk);
    `CHK(ram_we, 1'b0)
    i_host.wr(lrs_pkg::ADDR_STAT, 8'hFF);
    rd_chk(lrs_pkg::ADDR_XPTR, 8'h20);
    $display("test commands done");
  endtask
  // ****************************************************
  // Scan order
  // ****************************************************
  function automatic logic [6:0] pad(input int k, l, input bit m, b, t);
    int p;
    p = m ? l - 1 - k : k;
    if (b && p <= 15) p = 15 - p;
    else if (b && p >= 33 && p <= 47) p = 80 - p;
    else if (t && p >= 16 && p <= 32) p = 48 - p;
    else if (t && p >= 48) p = 112 - p;
    return p[6:0];
  endfunction
  task automatic next_line();
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (strobe !== 1'b1 && n < 20);
    `CHK(n <= 4, 1'b1)
  endtask
  task automatic icon_line();
    int n;
    n = 0;
    do begin
      next_line();
      n++;
    end while (scan_ram_row !== lrs_pkg::ICON_RAM_ROW && n < 70);
    `CHK(scan_ram_row, lrs_pkg::ICON_RAM_ROW)
  endtask
  // Lines are only counted per mux rate, since short rates skip rows
  task automatic scan_test();
    int lens[5] = '{16, 25, 32, 48, 64};
    logic [2:0] m;
    for (int r = 0; r < 5; r++) begin
      for (int c = 0; c < 8; c++) begin
        m = r[2:0];
        // Horizontal mode kept at every rate
        i_host.wr(lrs_pkg::ADDR_CTRL, {m, c[2:0], 2'b00});
        icon_line();
        icon_line();
        for (int k = 0; k <= lens[r]; k++) begin
          next_line();
          if (k == lens[r]) begin
            `CHK(scan_ram_row, 7'h40)
            `CHK(scan_row, c[2] ? 7'h30 : 7'h40)
          end else begin
            `CHK(scan_ram_row, k[6:0])
            `CHK(scan_row, pad(k, lens[r], c[0], c[1], c[2]))
          end
        end
      end
    end
    // Rows above
    $display("test scan done");
  endtask
  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    reset_test();
    ptr_test();
    cmd_test();
    scan_test();
    give_verdict();
  end
  initial begin
    #2000000;
    n_errors++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
